// File: psl_master_model.sv
// Partner model: fieldbus master doing object access
`timescale 1ns/1ps
module psl_master_model (
  // Clock
  input wire logic clk,
  // Object bus
  output logic obj_wr_en,
  output logic obj_rd_en,
  output logic [15:0] obj_index,
  output logic [31:0] obj_wdata,
  input wire logic [31:0] obj_rdata,
  input wire logic obj_rvalid
);
  // Idle bus at time zero
  initial begin
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h0000_0000;
  end
  // One write strobe; stale data inverted once released
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    @(negedge clk);
    obj_index = i;
    obj_wdata = d;
    obj_wr_en = 1'b1;
    @(negedge clk);
    obj_wr_en = 1'b0;
    obj_wdata = ~d;
  endtask
  // One read strobe, answer taken a cycle later
  task automatic rd(input logic [15:0] i, output logic [31:0] d,
                    output logic v);
    @(negedge clk);
    obj_index = i;
    obj_rd_en = 1'b1;
    @(negedge clk);
    obj_rd_en = 1'b0;
    obj_index = ~i;
    d = obj_rdata;
    v = obj_rvalid;
  endtask
  // Write then read of one object on back-to-back edges
  task automatic wrrd(input logic [15:0] i, input logic [31:0] wd,
                      output logic [31:0] d, output logic v);
    @(negedge clk);
    obj_index = i;
    obj_wdata = wd;
    obj_wr_en = 1'b1;
    @(negedge clk);
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b1;
    @(negedge clk);
    obj_rd_en = 1'b0;
    obj_wdata = ~wd;
    d = obj_rdata;
    v = obj_rvalid;
  endtask
endmodule // psl_master_model

// File: psl_monitor.sv
// Position settle and lag monitor with object access port
`timescale 1ns/1ps
// What this block does
// - Outside halt, settle flag rises only when enabled, set-points done, in window, dwell elapsed.
// - Outside halt, settle flag drops whenever the deviation leaves the settle window.
// - Outside halt, flag is 0 until positioning completes, then 1.
// - During halt, flag is 0 while decelerating, 1 once speed is zero.
// - Settle window is an unsigned 32-bit threshold compared with the deviation.
// - Settle dwell time is unsigned 16-bit in milliseconds before flag sets.
// - Tracking error equals position demand minus position actual.
// - Lag flag sets once error stays beyond lag window for the timeout.
// - Lag flag stays 0 inside window or before the timeout elapses.
// - Lag window is an unsigned 32-bit threshold over the full range.
// - Lag timeout is unsigned 16-bit in milliseconds of persisting excess.
module psl_monitor #(
  parameter int TICK_CYC = psl_pkg::PSL_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Object access from the fieldbus master
  input wire logic obj_wr_en,
  input wire logic obj_rd_en,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_wdata,
  output logic [31:0] obj_rdata,
  output logic obj_rvalid,
  // Drive state and motion status
  input wire logic op_enabled,
  input wire logic setpoints_done,
  input wire logic halt_active,
  input wire logic axis_speed_zero,
  // Position values in command units
  input wire logic [31:0] pos_demand,
  input wire logic [31:0] pos_actual,
  // Status flags and tracking error
  output logic settle_done,
  output logic lag_error,
  output logic [31:0] lag_value
);
  import psl_pkg::*;

  typedef struct packed {
    logic [31:0] lag_win;
    logic [15:0] lag_tmo;
    logic [31:0] set_win;
    logic [15:0] set_time;
    logic [15:0] tick_cnt;
    logic tick;
    logic [15:0] dwell_cnt;
    logic [15:0] lag_cnt;
    logic [31:0] fe;
    logic settle_done;
    logic lag_error;
    logic [31:0] rdata;
    logic rvalid;
  } psl_state_t;

  psl_state_t st_r;
  psl_state_t st_nxt;
  logic [31:0] abs_fe;
  logic in_set;
  logic out_lag;
  logic dwell_ok;
  logic tmo_ok;

  // Magnitude of the tracking error and window tests
  always_comb begin
    abs_fe = st_r.fe[31] ? (32'h0000_0000 - st_r.fe) : st_r.fe;
    in_set = (abs_fe <= st_r.set_win);
    out_lag = (abs_fe > st_r.lag_win);
    dwell_ok = (st_r.dwell_cnt >= st_r.set_time);
    tmo_ok = (st_r.lag_cnt >= st_r.lag_tmo);
  end

  // Next-state logic for all monitor state
  always_comb begin
    st_nxt = st_r;
    // Millisecond time base
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt == 16'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
    end
    // Tracking error, registered once per cycle
    st_nxt.fe = pos_demand - pos_actual;
    // Dwell counter only runs across an unbroken in-window stretch
    if (!in_set) begin
      st_nxt.dwell_cnt = 16'h0000;
    end else if (st_r.tick && st_r.dwell_cnt != PSL_CNT_MAX) begin
      st_nxt.dwell_cnt = st_r.dwell_cnt + 16'h0001;
    end
    // Lag counter only runs across an unbroken excess stretch
    if (!out_lag) begin
      st_nxt.lag_cnt = 16'h0000;
    end else if (st_r.tick && st_r.lag_cnt != PSL_CNT_MAX) begin
      st_nxt.lag_cnt = st_r.lag_cnt + 16'h0001;
    end
    // Settle flag: halt changes its meaning to axis standstill
    if (halt_active) begin
      st_nxt.settle_done = axis_speed_zero;
    end else if (!in_set) begin
      st_nxt.settle_done = 1'b0;
    end else begin
      st_nxt.settle_done = op_enabled && setpoints_done && dwell_ok;
    end
    // Lag flag follows a persisting excess only
    st_nxt.lag_error = out_lag && tmo_ok;
    // Object writes; 16-bit objects take the low half
    if (obj_wr_en) begin
      case (obj_index)
        PSL_LAG_WIN_IDX: st_nxt.lag_win = obj_wdata;
        PSL_LAG_TMO_IDX: st_nxt.lag_tmo = obj_wdata[15:0];
        PSL_SET_WIN_IDX: st_nxt.set_win = obj_wdata;
        PSL_SET_TIME_IDX: st_nxt.set_time = obj_wdata[15:0];
        default: ;
      endcase
    end
    // Object reads answer one cycle later; unknown indices read zero
    st_nxt.rvalid = obj_rd_en;
    if (obj_rd_en) begin
      case (obj_index)
        PSL_LAG_WIN_IDX: st_nxt.rdata = st_r.lag_win;
        PSL_LAG_TMO_IDX: st_nxt.rdata = {16'h0000, st_r.lag_tmo};
        PSL_SET_WIN_IDX: st_nxt.rdata = st_r.set_win;
        PSL_SET_TIME_IDX: st_nxt.rdata = {16'h0000, st_r.set_time};
        PSL_LAG_VAL_IDX: st_nxt.rdata = st_r.fe;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r.lag_win <= PSL_LAG_WIN_RST;
      st_r.lag_tmo <= PSL_LAG_TMO_RST;
      st_r.set_win <= PSL_SET_WIN_RST;
      st_r.set_time <= PSL_SET_TIME_RST;
      st_r.tick_cnt <= 16'h0000;
      st_r.tick <= 1'b0;
      st_r.dwell_cnt <= 16'h0000;
      st_r.lag_cnt <= 16'h0000;
      st_r.fe <= 32'h0000_0000;
      st_r.settle_done <= 1'b0;
      st_r.lag_error <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign obj_rdata = st_r.rdata;
  assign obj_rvalid = st_r.rvalid;
  assign settle_done = st_r.settle_done;
  assign lag_error = st_r.lag_error;
  assign lag_value = st_r.fe;

  // Checks on the monitor behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence settled_s;
    !halt_active && in_set && op_enabled && setpoints_done && dwell_ok;
  endsequence

  sequence broke_s;
    !halt_active && !in_set;
  endsequence

  settle_rise_a: assert property (
    !halt_active && !settle_done ##1 settle_done && !$past(halt_active)
    |-> $past(op_enabled && setpoints_done && in_set && dwell_ok))
    else $error("settle flag rose without its conditions");

  settle_drop_a: assert property (
    broke_s |=> !settle_done)
    else $error("settle flag held outside the window");

  settle_done_a: assert property (
    settled_s |=> settle_done)
    else $error("settle flag missing after positioning done");

  halt_view_a: assert property (
    halt_active |=> settle_done == $past(axis_speed_zero))
    else $error("settle flag wrong during halt");

  dwell_hold_a: assert property (
    in_set && !st_r.tick ##1 in_set |-> $stable(st_r.dwell_cnt))
    else $error("dwell counter moved without a tick");

  err_calc_a: assert property (
    1'b1 |=> lag_value == $past(pos_demand) - $past(pos_actual))
    else $error("tracking error not demand minus actual");

  lag_set_a: assert property (
    out_lag && tmo_ok |=> lag_error)
    else $error("lag flag missing after timeout");

  lag_quiet_a: assert property (
    !(out_lag && tmo_ok) |=> !lag_error)
    else $error("lag flag set too early");

  win_write_a: assert property (
    obj_wr_en && obj_index == PSL_SET_WIN_IDX
    |=> st_r.set_win == $past(obj_wdata))
    else $error("settle window write lost");

  tmo_write_a: assert property (
    obj_wr_en && obj_index == PSL_LAG_TMO_IDX
    |=> st_r.lag_tmo == $past(obj_wdata[15:0]))
    else $error("lag timeout write lost");

  lag_win_wr_a: assert property (
    obj_wr_en && obj_index == PSL_LAG_WIN_IDX ##1 obj_rd_en
    && obj_index == PSL_LAG_WIN_IDX ##1 1'b1
    |-> obj_rvalid && obj_rdata == $past(obj_wdata, 2))
    else $error("lag window readback wrong");

  cnt_restart_a: assert property (
    !out_lag |=> st_r.lag_cnt == 16'h0000)
    else $error("lag counter not restarted");

  dwell_restart_a: assert property (
    !in_set |=> st_r.dwell_cnt == 16'h0000)
    else $error("dwell counter not restarted");

  lag_step_a: assert property (
    out_lag && st_r.tick && st_r.lag_cnt != PSL_CNT_MAX
    |=> st_r.lag_cnt == $past(st_r.lag_cnt) + 16'h0001)
    else $error("lag counter missed a tick");

  time_write_a: assert property (
    obj_wr_en && obj_index == PSL_SET_TIME_IDX
    |=> st_r.set_time == $past(obj_wdata[15:0]))
    else $error("settle time write lost");

  read_pulse_a: assert property (
    obj_rd_en |=> obj_rvalid)
    else $error("read answer missing");

  read_quiet_a: assert property (
    !obj_rd_en |=> !obj_rvalid)
    else $error("read answer without a read");

  lag_hold_a: assert property (
    out_lag && !tmo_ok |=> !lag_error)
    else $error("lag flag before timeout");

endmodule // psl_monitor

// File: psl_pkg.sv
// Constants shared by the position settle and lag monitor
package psl_pkg;
  // Object indices for the threshold objects
  localparam logic [15:0] PSL_LAG_WIN_IDX = 16'h6065;
  localparam logic [15:0] PSL_LAG_TMO_IDX = 16'h6066;
  localparam logic [15:0] PSL_SET_WIN_IDX = 16'h6067;
  localparam logic [15:0] PSL_SET_TIME_IDX = 16'h6068;
  // Read-only view of the tracking error
  localparam logic [15:0] PSL_LAG_VAL_IDX = 16'h60f4;
  // Values after reset
  localparam logic [31:0] PSL_LAG_WIN_RST = 32'h0000_0000;
  localparam logic [15:0] PSL_LAG_TMO_RST = 16'h0000;
  localparam logic [31:0] PSL_SET_WIN_RST = 32'h0000_0000;
  localparam logic [15:0] PSL_SET_TIME_RST = 16'h0000;
  // Time base: clock period and millisecond tick
  localparam int PSL_CLK_PERIOD_NS = 40;
  localparam int PSL_TICK_PERIOD_NS = 1000000;
  localparam int PSL_TICK_CYCLES = PSL_TICK_PERIOD_NS / PSL_CLK_PERIOD_NS;
  // Saturation value of the millisecond counters
  localparam logic [15:0] PSL_CNT_MAX = 16'hffff;
  // Master cycle floor in profile position mode
  localparam int PSL_MIN_CYCLE_US = 250;
endpackage : psl_pkg

// File: test_position_settle_and_lag_monitor.sv
// Self-checking bench for the settle and lag monitor
`timescale 1ns/1ps
module test_position_settle_and_lag_monitor;
  import psl_pkg::*;
  localparam int TC = 4;
  typedef struct {logic [31:0] d, a; logic [3:0] c; logic s, l;} psl_row_t;
  logic clk, rstn, wr, rd, opn, spd, hlt, szr, sd, le, rv, gv;
  logic [15:0] idx;
  logic [31:0] wd, rdat, dem, act, lv, got;
  int miscompares, n_checks;
  logic [15:0] ri[6] = '{16'h6065, 16'h6066, 16'h6067, 16'h6068,
                         16'h6069, 16'h60f4};
  logic [31:0] re[6] = '{32'hffff_ffff, 32'h0000_ffff, 32'hffff_ffff,
                         32'h0000_ffff, 32'h0, 32'h0};
  // Control nibble is enable, set-points done, halt, speed zero
  psl_row_t rows[9] = '{
    '{32'ha, 32'h8, 4'hc, 1, 0}, '{32'ha, 32'hd, 4'hc, 0, 0},
    '{32'h5, 32'h7, 4'h4, 0, 0}, '{32'h5, 32'h7, 4'h8, 0, 0},
    '{32'h5, 32'h5, 4'he, 0, 0}, '{32'h5, 32'h5, 4'hf, 1, 0},
    '{32'h0, 32'h5, 4'hc, 0, 0}, '{32'h0, 32'h6, 4'hc, 0, 1},
    '{32'h8000_0000, 32'h0, 4'hc, 0, 1}};
  psl_monitor #(.TICK_CYC(TC)) i_dut (.clk(clk), .rstn(rstn),
    .obj_wr_en(wr), .obj_rd_en(rd), .obj_index(idx), .obj_wdata(wd),
    .obj_rdata(rdat), .obj_rvalid(rv), .op_enabled(opn),
    .setpoints_done(spd), .halt_active(hlt), .axis_speed_zero(szr),
    .pos_demand(dem), .pos_actual(act), .settle_done(sd),
    .lag_error(le), .lag_value(lv));
  psl_master_model i_mst (.clk(clk), .obj_wr_en(wr), .obj_rd_en(rd),
    .obj_index(idx), .obj_wdata(wd), .obj_rdata(rdat), .obj_rvalid(rv));
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Motion inputs change on the falling edge
  task automatic drv(input logic [31:0] d, a, input logic [3:0] c);
    @(negedge clk);
    dem = d;
    act = a;
    {opn, spd, hlt, szr} = c;
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    {opn, spd, hlt, szr} = 4'h0;
    dem = 32'h0;
    act = 32'h0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk(sd, 0);
    chk(le, 0);
    foreach (ri[i]) begin
      i_mst.rd(ri[i], got, gv);
      chk(got, 0);
      chk(gv, 1);
      i_mst.wr(ri[i], 32'hffff_ffff);
      i_mst.rd(ri[i], got, gv);
      chk(got, re[i]);
    end
    $display("test registers done");
    i_mst.wr(16'h6065, 32'h5);
    i_mst.wr(16'h6066, 32'h0);
    i_mst.wr(16'h6067, 32'h2);
    i_mst.wr(16'h6068, 32'h0);
    foreach (rows[i]) begin
      drv(rows[i].d, rows[i].a, rows[i].c);
      repeat (3) @(negedge clk);
      chk(sd, rows[i].s);
      chk(le, rows[i].l);
      chk(lv, rows[i].d - rows[i].a);
    end
    $display("test table done");
    i_mst.wr(16'h6068, 32'h3);
    i_mst.wr(16'h6066, 32'h2);
    drv(32'ha, 32'ha, 4'hc);
    repeat (3) @(negedge clk);
    chk(sd, 0);
    repeat (3 * TC + 3) @(negedge clk);
    chk(sd, 1);
    drv(32'ha, 32'h14, 4'hc);
    drv(32'ha, 32'ha, 4'hc);
    repeat (3) @(negedge clk);
    chk(sd, 0);
    chk(le, 0);
    drv(32'h0, 32'ha, 4'hc);
    repeat (3) @(negedge clk);
    chk(le, 0);
    repeat (2 * TC + 3) @(negedge clk);
    chk(le, 1);
    i_mst.rd(16'h60f4, got, gv);
    chk(got, 32'hffff_fff6);
    $display("test timing done");
    i_mst.wrrd(16'h6065, 32'h1234_5678, got, gv);
    chk(got, 32'h1234_5678);
    chk(gv, 1);
    $display("test write readback done");
    drv(32'h0, 32'h0, 4'hc);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    chk(sd, 0);
    chk(le, 0);
    chk(lv, 0);
    rstn = 1'b1;
    i_mst.rd(16'h6067, got, gv);
    chk(got, 0);
    chk(sd, 1);
    $display("test mid reset done");
    print_verdict();
  end
endmodule // test_position_settle_and_lag_monitor
